// ===== dv/cicsu_core_model.sv
`timescale 1ns/100ps
module cicsu_core_model (
    // clock and reset
    input  wire logic clock_in,
    input  wire logic srst_in,
    // interrupt lines from the block
    input  wire logic irq_in,
    input  wire logic fiq_in,
    // levels the core has taken in
    output logic      irq_seen_out,
    output logic      fiq_seen_out
);
    // ----------------------------------------------------------------
    // core sampling
    // ----------------------------------------------------------------
    // the core samples its lines on the block's clock, so levels arrive one edge late
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            irq_seen_out <= 1'b0;
            fiq_seen_out <= 1'b0;
        end else begin
            irq_seen_out <= irq_in;
            fiq_seen_out <= fiq_in;
        end
    end
endmodule

// ===== dv/cpu_if_ctrl_secure_upper_bench.sv
`timescale 1ns/100ps
module cpu_if_ctrl_secure_upper_bench;
    import cicsu_pkg::*;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic        clock_in = 1'b0;
    logic        srst_in  = 1'b1;
    cicsu_req_s  req      = '0;
    logic [31:0] rdata, rdata_v1, rdata_sv, d;
    logic        irq_en = 0, fiq_en = 0, c_irq = 0, c_fiq = 0, b_irq = 0, b_fiq = 0;
    logic        irq_o, fiq_o, irq_v1, fiq_v1, irq_sv, fiq_sv, irq_seen, fiq_seen;
    cicsu_act_s  act, act_v1, act_sv;
    logic        m_s = 0, m_ns = 0, m_ib = 0, m_fb = 0;
    logic        m_sv = 0, m_sv_ib = 0, m_sv_fb = 0;
    int          errors = 0;
    int          num_checks = 0;

    always #10 clock_in = ~clock_in;

    // ----------------------------------------------------------------
    // design instances: full, early and single-view variants on shared inputs
    // ----------------------------------------------------------------
    cicsu_ctrl_upper #(.ARCH_V2(1'b1), .HAS_SEC(1'b1)) u_dut (
        .clock_in(clock_in), .srst_in(srst_in), .bus_req_in(req), .rdata_out(rdata),
        .irq_sig_en_in(irq_en), .fiq_sig_en_in(fiq_en), .core_irq_in(c_irq), .core_fiq_in(c_fiq),
        .bypass_irq_in(b_irq), .bypass_fiq_in(b_fiq), .irq_out(irq_o), .fiq_out(fiq_o), .act_out(act));
    cicsu_ctrl_upper #(.ARCH_V2(1'b0), .HAS_SEC(1'b1)) u_v1_dut (
        .clock_in(clock_in), .srst_in(srst_in), .bus_req_in(req), .rdata_out(rdata_v1),
        .irq_sig_en_in(irq_en), .fiq_sig_en_in(fiq_en), .core_irq_in(c_irq), .core_fiq_in(c_fiq),
        .bypass_irq_in(b_irq), .bypass_fiq_in(b_fiq), .irq_out(irq_v1), .fiq_out(fiq_v1),
        .act_out(act_v1));
    cicsu_ctrl_upper #(.ARCH_V2(1'b1), .HAS_SEC(1'b0)) u_sv_dut (
        .clock_in(clock_in), .srst_in(srst_in), .bus_req_in(req), .rdata_out(rdata_sv),
        .irq_sig_en_in(irq_en), .fiq_sig_en_in(fiq_en), .core_irq_in(c_irq), .core_fiq_in(c_fiq),
        .bypass_irq_in(b_irq), .bypass_fiq_in(b_fiq), .irq_out(irq_sv), .fiq_out(fiq_sv),
        .act_out(act_sv));
    cicsu_core_model u_core (
        .clock_in(clock_in), .srst_in(srst_in), .irq_in(irq_o), .fiq_in(fiq_o),
        .irq_seen_out(irq_seen), .fiq_seen_out(fiq_seen));

    // ----------------------------------------------------------------
    // shared tasks and expectation functions
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // one bus cycle; returns 1 ns after the taking edge, where read data and act pulses stand
    task automatic bus(input logic w, input logic sec, input logic [7:0] a, input logic [31:0] dat);
        @(posedge clock_in);
        req <= '{wr: w, rd: !w, secure: sec, addr: a, wdata: dat};
        @(posedge clock_in);
        req.wr <= 1'b0;
        req.rd <= 1'b0;
        #1;
    endtask

    // expected control view for a secure or non-secure reader
    function automatic logic [31:0] view(input logic sec);
        view = '0;
        if (sec) begin
            view[10:7] = {m_ns, m_s, m_ib, m_fb};
        end else begin
            view[9] = m_ns;
            view[6] = m_ib;
            view[5] = m_fb;
        end
    endfunction

    task automatic wr_ctrl(input logic sec, input logic [31:0] dat);
        bus(1'b1, sec, OFF_CTRL, dat);
        if (sec) begin
            {m_ns, m_s, m_ib, m_fb} = dat[10:7];
        end else begin
            {m_ns, m_ib, m_fb} = {dat[9], dat[6], dat[5]};
        end
        // without security every access uses the single layout
        {m_sv, m_sv_ib, m_sv_fb} = dat[9:7];
    endtask

    task automatic eoi_dir(input logic sec, input logic is_dir);
        logic       mode;
        logic [9:0] id;
        mode = sec ? m_s : m_ns;
        id = 10'($urandom);
        bus(1'b1, sec, is_dir ? OFF_DIR : OFF_EOI, {$urandom} & 32'hffff_fc00 | {22'h0, id});
        check("act", 32'(act), {20'h0, !is_dir, is_dir ? mode : !mode, id});
        check("act_v1", 32'(act_v1), {20'h0, !is_dir, !is_dir, id});
        check("act_sv", 32'(act_sv), {20'h0, !is_dir, is_dir ? m_sv : !m_sv, id});
        bus(1'b0, sec, OFF_STATUS, 32'h0);
        check("unpred", rdata[0], is_dir && !mode);
        check("unpred_sv", rdata_sv[0], is_dir && !m_sv);
        bus(1'b1, sec, OFF_STATUS, 32'h1);
    endtask

    // ----------------------------------------------------------------
    // watchdog
    // ----------------------------------------------------------------
    initial begin
        #1000000;
        errors++;
        tally_and_finish();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'h524154e4));
        repeat (2) @(posedge clock_in);
        srst_in <= 1'b0;
        // reset values of both views
        bus(1'b0, 1'b1, OFF_CTRL, 32'h0);
        check("ctrl_s_reset", rdata, 32'h0);
        bus(1'b0, 1'b0, OFF_CTRL, 32'h0);
        check("ctrl_ns_reset", rdata, 32'h0);
        $display("reset test done");
        // random writes through either view, read back through both
        repeat (24) begin
            d = $urandom;
            wr_ctrl(1'($urandom), d);
            // non-secure read right after the write exercises the shared storage
            bus(1'b0, 1'b0, OFF_CTRL, 32'h0);
            check("ctrl_ns", rdata, view(1'b0));
            check("ctrl_sv", rdata_sv, {21'h0, 1'b0, m_sv, m_sv_ib, m_sv_fb, 7'h0});
            bus(1'b0, 1'b1, OFF_CTRL, 32'h0);
            check("ctrl_s", rdata, view(1'b1));
            check("ctrl_v1", rdata_v1, 32'h0);
        end
        bus(1'b1, 1'b1, 8'h10, 32'hffff_ffff);
        bus(1'b0, 1'b1, 8'h10, 32'h0);
        check("unmapped", rdata, 32'h0);
        bus(1'b0, 1'b1, OFF_CTRL, 32'h0);
        check("ctrl_kept", rdata, view(1'b1));
        $display("alias test done");
        // every pairing of secure and non-secure modes, both requesters, both registers
        for (int k = 0; k < 4; k++) begin
            wr_ctrl(1'b1, {21'h0, k[1], k[0], 9'h0});
            for (int s = 0; s < 4; s++) begin
                eoi_dir(s[1], s[0]);
            end
        end
        $display("end of interrupt test done");
        // interrupt lines with signalling on and off, bypass disabled or passed
        repeat (32) begin
            wr_ctrl(1'b1, $urandom);
            @(posedge clock_in);
            {irq_en, fiq_en, c_irq, c_fiq, b_irq, b_fiq} <= 6'($urandom);
            repeat (5) @(posedge clock_in);
            #1;
            check("irq", irq_o, irq_en ? c_irq : b_irq & !m_ib);
            check("fiq", fiq_o, fiq_en ? c_fiq : b_fiq & !m_fb);
            check("irq_v1", irq_v1, irq_en ? c_irq : b_irq);
            check("fiq_v1", fiq_v1, fiq_en ? c_fiq : b_fiq);
            check("irq_sv", irq_sv, irq_en ? c_irq : b_irq & !m_sv_ib);
            check("fiq_sv", fiq_sv, fiq_en ? c_fiq : b_fiq & !m_sv_fb);
            check("core_seen", {irq_seen, fiq_seen}, {irq_o, fiq_o});
        end
        $display("bypass test done");
        tally_and_finish();
    end
endmodule

// ===== src/cicsu_ctrl_upper.sv
// Contract
// - The secure/single control layout is used in a v2 design without security and for secure views with it.
// - Bit 10 of the secure view is the same storage as the non-secure view's split eoi mode bit.
// - In v2 without security, bit 10 is reserved and no aliased storage is provided.
// - With split mode 0 an eoi write drops priority and deactivates; deactivate writes are unpredictable.
// - With split mode 1 an eoi write only drops priority; the deactivate register deactivates.
// - With security, bit 9 governs secure accesses only; non-secure ones follow the non-secure mode bit.
// - Without security, bit 9 is the single mode control for all eoi and deactivate accesses.
// - Bit 8 aliases the non-secure view's group 1 irq bypass-disable bit with one shared storage element.
// - Bit 7 aliases the non-secure view's group 1 fiq bypass-disable bit with one shared storage element.
// - In a v1 design bits 10 to 7 are reserved with no split mode or bypass-disable function.
// - With irq signalling off, irq bypass-disable at 1 blocks the bypass irq; at 0 it is passed.
// - With fiq signalling off, fiq bypass-disable at 1 blocks the bypass fiq; at 0 it is passed.
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module cicsu_ctrl_upper #(
    parameter bit ARCH_V2 = 1'b1,
    parameter bit HAS_SEC = 1'b1
) (
    // clock and reset
    input  wire logic                  clock_in,
    input  wire logic                  srst_in,
    // register port
    input  cicsu_pkg::cicsu_req_s      bus_req_in,
    output logic [31:0]                rdata_out,
    // cpu interface signalling, same clock
    input  wire logic                  irq_sig_en_in,
    input  wire logic                  fiq_sig_en_in,
    input  wire logic                  core_irq_in,
    input  wire logic                  core_fiq_in,
    // bypass pins, asynchronous
    input  wire logic                  bypass_irq_in,
    input  wire logic                  bypass_fiq_in,
    // toward the processor
    output logic                       irq_out,
    output logic                       fiq_out,
    // toward the priority and active logic
    output cicsu_pkg::cicsu_act_s      act_out
);
    import cicsu_pkg::*;

    // ----------------------------------------------------------------
    // variant decode
    // ----------------------------------------------------------------
    localparam bit SEC_V2 = ARCH_V2 && HAS_SEC;

    logic              nonsecure_split_eoi_mode_reg;
    logic              secure_split_eoi_mode_reg;
    logic              grp1_irq_bypass_disable_reg;
    logic              grp1_fiq_bypass_disable_reg;
    logic              unpred_reg;
    logic              unpred_pulse;
    logic [1:0]        bypass_sync;
    logic              ns_view;
    logic              wr_ctrl;
    logic              split_eff;
    logic [31:0]       ctrl_view;
    logic [31:0]       rdata_next;

    // a non-secure access only sees its own layout when security exists
    assign ns_view = SEC_V2 && !bus_req_in.secure;
    assign wr_ctrl = bus_req_in.wr && (bus_req_in.addr == OFF_CTRL);

    // ----------------------------------------------------------------
    // control storage
    // ----------------------------------------------------------------
    // secure-view split mode; in v1 it never leaves reset
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            secure_split_eoi_mode_reg <= RST_MODE;
        end else if (wr_ctrl && ARCH_V2 && !ns_view) begin
            secure_split_eoi_mode_reg <= bus_req_in.wdata[S_BIT_MODE];
        end
    end

    // one storage for the non-secure mode, written from either view
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            nonsecure_split_eoi_mode_reg <= RST_MODE;
        end else if (wr_ctrl && SEC_V2) begin
            if (ns_view) begin
                nonsecure_split_eoi_mode_reg <= bus_req_in.wdata[N_BIT_MODE];
            end else begin
                nonsecure_split_eoi_mode_reg <= bus_req_in.wdata[S_BIT_NS_MODE];
            end
        end
    end

    // bypass disables shared by both views at different bit positions
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            grp1_irq_bypass_disable_reg <= RST_BYPASS;
            grp1_fiq_bypass_disable_reg <= RST_BYPASS;
        end else if (wr_ctrl && ARCH_V2) begin
            if (ns_view) begin
                grp1_irq_bypass_disable_reg <= bus_req_in.wdata[N_BIT_IRQ_BYP];
                grp1_fiq_bypass_disable_reg <= bus_req_in.wdata[N_BIT_FIQ_BYP];
            end else begin
                grp1_irq_bypass_disable_reg <= bus_req_in.wdata[S_BIT_IRQ_BYP];
                grp1_fiq_bypass_disable_reg <= bus_req_in.wdata[S_BIT_FIQ_BYP];
            end
        end
    end

    // ----------------------------------------------------------------
    // end-of-interrupt handling
    // ----------------------------------------------------------------
    // without security the secure bit is the only control
    assign split_eff = ns_view ? nonsecure_split_eoi_mode_reg
                               : secure_split_eoi_mode_reg;

    cicsu_eoi u_eoi (
        .clock_in    (clock_in),
        .srst_in     (srst_in),
        .eoi_wr_in   (bus_req_in.wr && (bus_req_in.addr == OFF_EOI)),
        .dir_wr_in   (bus_req_in.wr && (bus_req_in.addr == OFF_DIR)),
        .id_in       (bus_req_in.wdata[ID_W-1:0]),
        .split_in    (split_eff),
        .split_ok_in (ARCH_V2),
        .act_out     (act_out),
        .unpred_out  (unpred_pulse)
    );

    // sticky flag for ignored deactivates; a new event beats the clear
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            unpred_reg <= 1'b0;
        end else if (unpred_pulse) begin
            unpred_reg <= 1'b1;
        end else if (bus_req_in.wr && (bus_req_in.addr == OFF_STATUS)
                     && bus_req_in.wdata[ST_BIT_UNPRED]) begin
            unpred_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // bypass path
    // ----------------------------------------------------------------
    cicsu_sync #(.W(2)) u_sync (
        .clock_in (clock_in),
        .srst_in  (srst_in),
        .async_in ({bypass_fiq_in, bypass_irq_in}),
        .sync_out (bypass_sync)
    );

    // the cpu interface owns the line while its signalling is on;
    // registering the mux costs one cycle but keeps the pin glitch free
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            irq_out <= 1'b0;
            fiq_out <= 1'b0;
        end else begin
            irq_out <= irq_sig_en_in ? core_irq_in
                     : (bypass_sync[0] && !grp1_irq_bypass_disable_reg);
            fiq_out <= fiq_sig_en_in ? core_fiq_in
                     : (bypass_sync[1] && !grp1_fiq_bypass_disable_reg);
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // build the view seen by this access; everything else stays zero
    always_comb begin
        ctrl_view = '0;
        if (ARCH_V2) begin
            if (ns_view) begin
                ctrl_view[N_BIT_MODE]    = nonsecure_split_eoi_mode_reg;
                ctrl_view[N_BIT_IRQ_BYP] = grp1_irq_bypass_disable_reg;
                ctrl_view[N_BIT_FIQ_BYP] = grp1_fiq_bypass_disable_reg;
            end else begin
                ctrl_view[S_BIT_NS_MODE] = SEC_V2 && nonsecure_split_eoi_mode_reg;
                ctrl_view[S_BIT_MODE]    = secure_split_eoi_mode_reg;
                ctrl_view[S_BIT_IRQ_BYP] = grp1_irq_bypass_disable_reg;
                ctrl_view[S_BIT_FIQ_BYP] = grp1_fiq_bypass_disable_reg;
            end
        end
    end

    always_comb begin
        rdata_next = '0;
        if (bus_req_in.rd) begin
            unique case (bus_req_in.addr)
                OFF_CTRL: begin
                    rdata_next = ctrl_view;
                end
                OFF_STATUS: begin
                    rdata_next[ST_BIT_UNPRED] = unpred_reg;
                    rdata_next[ST_BIT_IRQ]    = irq_out;
                    rdata_next[ST_BIT_FIQ]    = fiq_out;
                end
                default: begin
                    rdata_next = '0;
                end
            endcase
        end
    end

    // data stands for the one cycle after the strobe only
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            rdata_out <= '0;
        end else begin
            rdata_out <= rdata_next;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);

    a_eoi_split_drop: assert property (
        bus_req_in.wr && bus_req_in.addr == OFF_EOI && ARCH_V2 && split_eff
        |=> act_out.drop && !act_out.deact)
        else $error("split eoi deactivated");

    a_eoi_full_drop: assert property (
        bus_req_in.wr && bus_req_in.addr == OFF_EOI && !split_eff
        |=> act_out.drop && act_out.deact)
        else $error("eoi without split did not deactivate");

    a_dir_split_deact: assert property (
        bus_req_in.wr && bus_req_in.addr == OFF_DIR && ARCH_V2 && split_eff
        |=> act_out.deact && !act_out.drop && !unpred_pulse)
        else $error("dir did not deactivate in split mode");

    a_dir_unpred_flag: assert property (
        bus_req_in.wr && bus_req_in.addr == OFF_DIR && !split_eff
        |=> !act_out.deact ##1 unpred_reg)
        else $error("ignored dir not flagged");

    a_ns_mode_select: assert property (
        bus_req_in.wr && bus_req_in.addr == OFF_EOI && ns_view
        && nonsecure_split_eoi_mode_reg != secure_split_eoi_mode_reg
        |=> act_out.deact == !$past(nonsecure_split_eoi_mode_reg))
        else $error("non-secure eoi used wrong mode");

    a_alias_ns_mode: assert property (
        bus_req_in.rd && bus_req_in.addr == OFF_CTRL && !ns_view
        |=> rdata_out[S_BIT_NS_MODE] == (SEC_V2 && $past(nonsecure_split_eoi_mode_reg)))
        else $error("bit 10 not aliased");

    a_alias_irq_byp: assert property (
        wr_ctrl && ARCH_V2 && !ns_view ##1 !wr_ctrl ##1 bus_req_in.rd && bus_req_in.addr == OFF_CTRL
        && ns_view |=> rdata_out[N_BIT_IRQ_BYP] == $past(bus_req_in.wdata[S_BIT_IRQ_BYP], 3))
        else $error("irq bypass disable not shared");

    a_alias_fiq_byp: assert property (
        wr_ctrl && ARCH_V2 && !ns_view |=> grp1_fiq_bypass_disable_reg
        == $past(bus_req_in.wdata[S_BIT_FIQ_BYP]))
        else $error("fiq bypass disable not stored");

    a_irq_bypass_gate: assert property (
        !irq_sig_en_in && grp1_irq_bypass_disable_reg |=> !irq_out)
        else $error("bypass irq leaked");

    a_fiq_bypass_pass: assert property (
        !fiq_sig_en_in && !grp1_fiq_bypass_disable_reg && bypass_sync[1] |=> fiq_out)
        else $error("bypass fiq not passed");

    a_reserved_zero: assert property (
        rdata_out[31:S_BIT_NS_MODE+1] == '0 && (ARCH_V2 || rdata_out[S_BIT_NS_MODE:S_BIT_FIQ_BYP] == '0))
        else $error("reserved bits read nonzero");

    a_read_one_cycle: assert property (
        !bus_req_in.rd |=> rdata_out == '0)
        else $error("read data held too long");

    // ----------------------------------------------------------------
    // storage, mode selection and line routing checks
    // ----------------------------------------------------------------

    a_sec_mode_store: assert property (
        wr_ctrl && ARCH_V2 && !ns_view
        |=> secure_split_eoi_mode_reg == $past(bus_req_in.wdata[S_BIT_MODE]))
        else $error("secure split mode not stored");

    a_ns_mode_store: assert property (
        wr_ctrl && ns_view
        |=> nonsecure_split_eoi_mode_reg == $past(bus_req_in.wdata[N_BIT_MODE]))
        else $error("non-secure split mode not stored");

    a_alias_ns_write: assert property (
        wr_ctrl && SEC_V2 && !ns_view
        |=> nonsecure_split_eoi_mode_reg == $past(bus_req_in.wdata[S_BIT_NS_MODE]))
        else $error("bit 10 write missed shared storage");

    a_no_alias_store: assert property (
        !SEC_V2 |-> !nonsecure_split_eoi_mode_reg)
        else $error("aliased mode storage without security");

    a_sec_mode_select: assert property (
        bus_req_in.wr && bus_req_in.addr == OFF_EOI && SEC_V2 && bus_req_in.secure
        |=> act_out.deact == !$past(secure_split_eoi_mode_reg))
        else $error("secure eoi used wrong mode");

    a_single_mode: assert property (
        bus_req_in.wr && bus_req_in.addr == OFF_EOI && ARCH_V2 && !HAS_SEC
        |=> act_out.deact == !$past(secure_split_eoi_mode_reg))
        else $error("single mode not applied to eoi write");

    a_v1_reserved: assert property (
        !ARCH_V2 |-> !secure_split_eoi_mode_reg && !grp1_irq_bypass_disable_reg
                  && !grp1_fiq_bypass_disable_reg)
        else $error("early variant stored a reserved bit");

    a_v1_dir_idle: assert property (
        bus_req_in.wr && bus_req_in.addr == OFF_DIR && !ARCH_V2
        |=> !act_out.deact && !act_out.drop)
        else $error("early variant deactivate register acted");

    a_irq_bypass_pass: assert property (
        !irq_sig_en_in && !grp1_irq_bypass_disable_reg && bypass_sync[0] |=> irq_out)
        else $error("bypass irq not passed");

    a_fiq_bypass_gate: assert property (
        !fiq_sig_en_in && grp1_fiq_bypass_disable_reg |=> !fiq_out)
        else $error("bypass fiq leaked");

    a_core_irq_path: assert property (
        irq_sig_en_in |=> irq_out == $past(core_irq_in))
        else $error("irq not from cpu interface");

    a_core_fiq_path: assert property (
        fiq_sig_en_in |=> fiq_out == $past(core_fiq_in))
        else $error("fiq not from cpu interface");

    a_eoi_id_taken: assert property (
        bus_req_in.wr && (bus_req_in.addr == OFF_EOI || bus_req_in.addr == OFF_DIR)
        |=> act_out.id == $past(bus_req_in.wdata[ID_W-1:0]))
        else $error("interrupt id not taken");

    a_unpred_sticky: assert property (
        unpred_reg && !(bus_req_in.wr && bus_req_in.addr == OFF_STATUS) |=> unpred_reg)
        else $error("unpredictable flag lost");

    a_ns_view_fiq: assert property (
        bus_req_in.rd && bus_req_in.addr == OFF_CTRL && ns_view
        |=> rdata_out[N_BIT_FIQ_BYP] == $past(grp1_fiq_bypass_disable_reg))
        else $error("fiq bypass disable not shared with non-secure view");

    a_status_flag_read: assert property (
        bus_req_in.rd && bus_req_in.addr == OFF_STATUS
        |=> rdata_out[ST_BIT_UNPRED] == $past(unpred_reg))
        else $error("status read lost the flag");

endmodule

// ===== src/cicsu_eoi.sv
`timescale 1ns/100ps
module cicsu_eoi (
    // clock and reset
    input  wire logic                  clock_in,
    input  wire logic                  srst_in,
    // requests
    input  wire logic                  eoi_wr_in,
    input  wire logic                  dir_wr_in,
    input  wire logic [cicsu_pkg::ID_W-1:0] id_in,
    // governing mode for this access
    input  wire logic                  split_in,
    input  wire logic                  split_ok_in,
    // actions toward the core logic
    output cicsu_pkg::cicsu_act_s      act_out,
    output logic                       unpred_out
);
    import cicsu_pkg::*;

    // ----------------------------------------------------------------
    // end-of-interrupt and deactivate decode
    // ----------------------------------------------------------------
    // split off: eoi drops and deactivates, dir is unpredictable
    // split on: eoi only drops, dir deactivates
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            act_out    <= '0;
            unpred_out <= 1'b0;
        end else begin
            act_out.drop  <= eoi_wr_in;
            act_out.deact <= (eoi_wr_in && !(split_ok_in && split_in))
                          || (dir_wr_in && split_ok_in && split_in);
            act_out.id    <= (eoi_wr_in || dir_wr_in) ? id_in : act_out.id;
            // dir with split off is ignored and only flagged
            unpred_out    <= dir_wr_in && !(split_ok_in && split_in);
        end
    end
endmodule

// ===== src/cicsu_pkg.sv
package cicsu_pkg;

    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_EOI    = 8'h04;
    localparam logic [7:0] OFF_DIR    = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    // secure or single-view layout
    localparam int unsigned S_BIT_NS_MODE = 10;
    localparam int unsigned S_BIT_MODE    = 9;
    localparam int unsigned S_BIT_IRQ_BYP = 8;
    localparam int unsigned S_BIT_FIQ_BYP = 7;
    // non-secure view layout
    localparam int unsigned N_BIT_MODE    = 9;
    localparam int unsigned N_BIT_IRQ_BYP = 6;
    localparam int unsigned N_BIT_FIQ_BYP = 5;
    // status register
    localparam int unsigned ST_BIT_UNPRED = 0;
    localparam int unsigned ST_BIT_IRQ    = 1;
    localparam int unsigned ST_BIT_FIQ    = 2;

    // ----------------------------------------------------------------
    // reset values and widths
    // ----------------------------------------------------------------
    localparam logic RST_MODE   = 1'b0;
    localparam logic RST_BYPASS = 1'b0;
    localparam int unsigned ID_W = 10;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic        secure;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } cicsu_req_s;

    typedef struct packed {
        logic            drop;
        logic            deact;
        logic [ID_W-1:0] id;
    } cicsu_act_s;

endpackage

// ===== src/cicsu_sync.sv
`timescale 1ns/100ps
module cicsu_sync #(
    parameter int unsigned W = 2
) (
    // clock and reset
    input  wire logic         clock_in,
    input  wire logic         srst_in,
    // levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    import cicsu_pkg::*;

    logic [W-1:0] meta_reg;

    // two stages per bit; first stage feeds only the second
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clock_in) begin
            if (srst_in) begin
                meta_reg[i] <= 1'b0;
                sync_out[i] <= 1'b0;
            end else begin
                meta_reg[i] <= async_in[i];
                sync_out[i] <= meta_reg[i];
            end
        end
    end
endmodule
